// >>> logic/dbsp_port.sv
// Purpose: double-data-rate burst sram port with its storage
// Assumes: k and k_n are sampled levels, much slower than clk
// Notes: write beats are posted through a 32-entry buffer to the arrays
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - write data sampled on k and k_n rises
// - read words driven on k and k_n rises
// - outputs released when no read is active
// - low load strobe defines a cycle at k
// - every access moves exactly two words
// - each active-low mask selects a 9-bit lane
// - mask taken on same edge as its beat
// - masked-off lane leaves stored data unchanged
// - one shared address sampled at k rise
// - storage is two arrays of 512K words
// - direction high reads, low writes
// - accesses begin only on k rise
// - read-valid flag marks driven output data
module dbsp_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic k,
  input wire logic k_n,
  input wire logic load_strobe_n,
  input wire logic dir,
  input wire logic [dbsp_pkg::ADDR_W-1:0] addr,
  input wire logic [dbsp_pkg::DATA_W-1:0] dq_in,
  output logic [dbsp_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [dbsp_pkg::LANES-1:0] lane_write_mask_n,
  output logic read_valid_flag,
  output logic [1:0] echo_strobes,
  output logic write_buffer_ready
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic k_prev;
    logic kn_prev;
    dbsp_pkg::dbsp_rd_state_t rd_state;
    logic rd_queued;
    logic rd_fetch;
    logic [dbsp_pkg::ADDR_W-1:0] rd_addr;
    logic [dbsp_pkg::DATA_W-1:0] beat1_word;
    logic wr_beat1_pend;
    logic [dbsp_pkg::ADDR_W-1:0] wr_addr;
    logic [dbsp_pkg::DATA_W-1:0] dq_out;
    logic dq_oe;
    logic valid;
    logic [1:0] echo;
  } dbsp_state_t;

  dbsp_state_t s_reg, s_next;

  logic k_rise, kn_rise;
  logic push_valid, push_ready;
  logic [dbsp_pkg::ENTRY_W-1:0] push_data;
  logic drain_valid, drain_ready, drain_fire;
  logic [dbsp_pkg::ENTRY_W-1:0] drain_data;
  logic [dbsp_pkg::ADDR_W-1:0] drain_addr;
  logic drain_beat;
  logic [dbsp_pkg::LANES-1:0] drain_mask_n;
  logic [dbsp_pkg::DATA_W-1:0] drain_word, drain_old, drain_merged;
  logic [dbsp_pkg::DATA_W-1:0] mem_q0, mem_q1;

  // two arrays: first beat and second beat of each location
  logic [dbsp_pkg::DATA_W-1:0] array_even [dbsp_pkg::ARRAY_DEPTH];
  logic [dbsp_pkg::DATA_W-1:0] array_odd [dbsp_pkg::ARRAY_DEPTH];

  assign k_rise = k && !s_reg.k_prev;
  assign kn_rise = k_n && !s_reg.kn_prev;

  // ****************************************************
  // command, write capture and read sequencing
  // ****************************************************
  always_comb begin
    s_next = s_reg;
    push_valid = 1'b0;
    push_data = '0;
    s_next.k_prev = k;
    s_next.kn_prev = k_n;
    s_next.echo = {k_n, k};
    s_next.rd_fetch = 1'b0;

    // second write beat on the complementary edge
    if (kn_rise && s_reg.wr_beat1_pend) begin
      push_valid = 1'b1;
      push_data = {s_reg.wr_addr, 1'b1, lane_write_mask_n, dq_in};
      s_next.wr_beat1_pend = 1'b0;
    end

    // second read word on the complementary edge
    unique case (s_reg.rd_state)
      dbsp_pkg::RD_IDLE: begin
      end
      dbsp_pkg::RD_BEAT1: begin
        if (kn_rise) begin
          s_next.dq_out = s_reg.beat1_word;
          s_next.rd_state = dbsp_pkg::RD_IDLE;
        end
      end
    endcase

    if (k_rise) begin
      // first read word of a queued read, else release the pins
      if (s_reg.rd_queued) begin
        s_next.dq_out = mem_q0;
        s_next.dq_oe = 1'b1;
        s_next.valid = 1'b1;
        s_next.beat1_word = mem_q1;
        s_next.rd_state = dbsp_pkg::RD_BEAT1;
      end else begin
        s_next.dq_oe = 1'b0;
        s_next.valid = 1'b0;
        s_next.rd_state = dbsp_pkg::RD_IDLE;
      end
      s_next.rd_queued = 1'b0;
      // new command only with the load strobe low at k
      if (!load_strobe_n) begin
        if (dir) begin
          s_next.rd_queued = 1'b1;
          s_next.rd_fetch = 1'b1;
          s_next.rd_addr = addr;
        end else begin
          push_valid = 1'b1;
          push_data = {addr, 1'b0, lane_write_mask_n, dq_in};
          s_next.wr_beat1_pend = 1'b1;
          s_next.wr_addr = addr;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{
        k_prev: 1'b0, kn_prev: 1'b0, rd_state: dbsp_pkg::RD_IDLE,
        rd_queued: 1'b0, rd_fetch: 1'b0, rd_addr: '0,
        beat1_word: dbsp_pkg::DQ_RESET, wr_beat1_pend: 1'b0, wr_addr: '0,
        dq_out: dbsp_pkg::DQ_RESET, dq_oe: 1'b0, valid: 1'b0,
        echo: dbsp_pkg::ECHO_RESET
      };
    end else begin
      s_reg <= s_next;
    end
  end

  assign dq_out = s_reg.dq_out;
  assign dq_oe = s_reg.dq_oe;
  assign read_valid_flag = s_reg.valid;
  assign echo_strobes = s_reg.echo;
  assign write_buffer_ready = push_ready;

  // ****************************************************
  // write posting buffer
  // ****************************************************
  dbsp_fifo #(
    .WIDTH(dbsp_pkg::ENTRY_W),
    .DEPTH(dbsp_pkg::FIFO_DEPTH)
  ) u_wr_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_data)
  );

  // ****************************************************
  // storage arrays
  // ****************************************************
  // reads take the array port; posted writes wait a cycle
  assign drain_ready = !s_reg.rd_fetch;
  assign drain_fire = drain_valid && drain_ready;
  assign drain_addr = drain_data[dbsp_pkg::ENTRY_ADDR_LSB +: dbsp_pkg::ADDR_W];
  assign drain_beat = drain_data[dbsp_pkg::ENTRY_BEAT_BIT];
  assign drain_mask_n = drain_data[dbsp_pkg::ENTRY_MASK_LSB +: dbsp_pkg::LANES];
  assign drain_word = drain_data[dbsp_pkg::ENTRY_DATA_LSB +: dbsp_pkg::DATA_W];
  assign drain_old = drain_beat ? array_odd[drain_addr] : array_even[drain_addr];
  assign drain_merged = dbsp_pkg::lane_merge(drain_old, drain_word, drain_mask_n);

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_q0 <= dbsp_pkg::DQ_RESET;
      mem_q1 <= dbsp_pkg::DQ_RESET;
    end else if (s_reg.rd_fetch) begin
      mem_q0 <= array_even[s_reg.rd_addr];
      mem_q1 <= array_odd[s_reg.rd_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (drain_fire) begin
      if (drain_beat) begin
        array_odd[drain_addr] <= drain_merged;
      end else begin
        array_even[drain_addr] <= drain_merged;
      end
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd_cmd;
    k_rise && !load_strobe_n && dir;
  endsequence

  sequence s_wr_cmd;
    k_rise && !load_strobe_n && !dir;
  endsequence

  property p_rd_cmd;
    s_rd_cmd |=> s_reg.rd_queued && s_reg.rd_fetch && s_reg.rd_addr == $past(addr);
  endproperty
  a_rd_cmd: assert property (p_rd_cmd) else $error("read command not taken");

  property p_no_cmd_off_k;
    !k_rise |=> !s_reg.rd_fetch;
  endproperty
  a_no_cmd_off_k: assert property (p_no_cmd_off_k) else $error("access began off a k rise");

  property p_wr_beat0;
    s_wr_cmd |-> push_valid && push_data == {addr, 1'b0, lane_write_mask_n, dq_in};
  endproperty
  a_wr_beat0: assert property (p_wr_beat0) else $error("first write beat not captured");

  sequence s_wr_beat1;
    kn_rise && s_reg.wr_beat1_pend;
  endsequence

  property p_wr_beat1;
    s_wr_beat1 |->
      push_valid && push_data[dbsp_pkg::ENTRY_BEAT_BIT]
      && push_data[dbsp_pkg::ENTRY_DATA_LSB +: dbsp_pkg::DATA_W] == dq_in
      && push_data[dbsp_pkg::ENTRY_MASK_LSB +: dbsp_pkg::LANES] == lane_write_mask_n
      && push_data[dbsp_pkg::ENTRY_ADDR_LSB +: dbsp_pkg::ADDR_W] == s_reg.wr_addr;
  endproperty
  a_wr_beat1: assert property (p_wr_beat1) else $error("second write beat not captured");

  property p_rd_beat0;
    k_rise && s_reg.rd_queued |=> dq_oe && read_valid_flag && dq_out == $past(mem_q0);
  endproperty
  a_rd_beat0: assert property (p_rd_beat0) else $error("first read word not driven");

  property p_rd_beat1;
    kn_rise && s_reg.rd_state == dbsp_pkg::RD_BEAT1 |=> dq_oe && dq_out == $past(s_reg.beat1_word);
  endproperty
  a_rd_beat1: assert property (p_rd_beat1) else $error("second read word not driven");

  property p_hiz;
    k_rise && !s_reg.rd_queued |=> !dq_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs driven with no read");

  property p_valid_flag;
    dq_oe == read_valid_flag;
  endproperty
  a_valid_flag: assert property (p_valid_flag) else $error("read-valid flag out of step");

  property p_lane_write;
    drain_fire |=> (($past(drain_beat) ? array_odd[$past(drain_addr)] : array_even[$past(drain_addr)])
      == $past(drain_merged));
  endproperty
  a_lane_write: assert property (p_lane_write) else $error("lane write wrong");

  property p_mask_keep;
    drain_fire && drain_mask_n[0] |-> drain_merged[dbsp_pkg::LANE_W-1:0] == drain_old[dbsp_pkg::LANE_W-1:0];
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("masked lane altered");

  property p_mask_take;
    drain_fire && !drain_mask_n[dbsp_pkg::LANES-1] |->
      drain_merged[dbsp_pkg::DATA_W-1 -: dbsp_pkg::LANE_W] == drain_word[dbsp_pkg::DATA_W-1 -: dbsp_pkg::LANE_W];
  endproperty
  a_mask_take: assert property (p_mask_take) else $error("enabled lane not written");

  property p_fetch_pair;
    s_reg.rd_fetch |=> mem_q0 == $past(array_even[s_reg.rd_addr])
      && mem_q1 == $past(array_odd[s_reg.rd_addr]);
  endproperty
  a_fetch_pair: assert property (p_fetch_pair) else $error("read pair not fetched");

  property p_echo;
    !rst |=> echo_strobes == $past({k_n, k});
  endproperty
  a_echo: assert property (p_echo) else $error("echo strobes out of step");

  property p_oe_stands;
    !rst && !k_rise |=> $stable(dq_oe) && $stable(read_valid_flag);
  endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("output enable moved off a k rise");

  property p_valid_rise;
    $rose(read_valid_flag) |-> $past(k_rise) && $past(s_reg.rd_queued);
  endproperty
  a_valid_rise: assert property (p_valid_rise) else $error("read-valid raised with no queued read");

endmodule : dbsp_port
`default_nettype wire

// >>> logic/dbsp_pkg.sv
// Purpose: shared constants and types of the burst sram port
// Assumes: wide organisation, 36-bit words, two-word burst
// Notes: strobes and clocks of the link are sampled levels in clk domain
package dbsp_pkg;

  // ****************************************************
  // geometry
  // ****************************************************
  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int ADDR_W = 19;
  localparam int ARRAY_DEPTH = 1 << ADDR_W;
  localparam int BURST_LEN = 2;

  // ****************************************************
  // write posting buffer
  // ****************************************************
  localparam int FIFO_DEPTH = 32;
  localparam int ENTRY_W = ADDR_W + 1 + LANES + DATA_W;
  localparam int ENTRY_DATA_LSB = 0;
  localparam int ENTRY_MASK_LSB = DATA_W;
  localparam int ENTRY_BEAT_BIT = DATA_W + LANES;
  localparam int ENTRY_ADDR_LSB = DATA_W + LANES + 1;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [DATA_W-1:0] DQ_RESET = 36'h0_0000_0000;
  localparam logic [1:0] ECHO_RESET = 2'h0;

  // ****************************************************
  // read output sequencing
  // ****************************************************
  typedef enum logic {
    RD_IDLE,
    RD_BEAT1
  } dbsp_rd_state_t;

  // merge a beat into a stored word, lane by lane, mask active low
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [LANES-1:0] mask_n
  );
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < LANES; i++) begin
      if (!mask_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction : lane_merge

endpackage : dbsp_pkg

// >>> logic/dbsp_fifo.sv
// Purpose: synchronous fifo with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: width and depth shape the storage; depth is a power of two
`timescale 1ns/1ps
`default_nettype none
module dbsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
  } dbsp_fifo_state_t;

  dbsp_fifo_state_t s_reg, s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = (s_reg.count != (PW+1)'(DEPTH));
  assign out_valid = (s_reg.count != '0);
  assign out_data = mem[s_reg.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wptr = s_reg.wptr + 1'b1;
    end
    if (pop) begin
      s_next.rptr = s_reg.rptr + 1'b1;
    end
    s_next.count = s_reg.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_reg.wptr] <= in_data;
    end
  end

endmodule : dbsp_fifo
`default_nettype wire

// >>> dv/dbsp_ctrl_model.sv
// Purpose: controller model driving commands, addresses and write beats
// Assumes: link period of 16 clk cycles, k_n the inverse of k
// Notes: released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module dbsp_ctrl_model (
  input wire logic clk,
  output logic k,
  output logic k_n,
  output logic load_strobe_n,
  output logic dir,
  output logic [dbsp_pkg::ADDR_W-1:0] addr,
  output logic [dbsp_pkg::DATA_W-1:0] dq_in,
  output logic [dbsp_pkg::LANES-1:0] lane_write_mask_n
);
  initial begin
    k = 1'b0;
    k_n = 1'b1;
    load_strobe_n = 1'b1;
    dir = 1'b1;
    addr = '0;
    dq_in = '0;
    lane_write_mask_n = 4'hf;
  end
  // cmd: 0 idle, 1 write, 2 read, 3 idle with stray strobe off k rise
  task automatic cycle(input int cmd, input logic [dbsp_pkg::ADDR_W-1:0] a, input logic [35:0] d0,
      input logic [3:0] m0, input logic [35:0] d1, input logic [3:0] m1);
    k <= 1'b1;
    k_n <= 1'b0;
    load_strobe_n <= !(cmd == 1 || cmd == 2);
    dir <= (cmd == 2);
    addr <= (cmd == 1 || cmd == 2) ? a : ~addr;
    dq_in <= (cmd == 1) ? d0 : ~dq_in;
    lane_write_mask_n <= m0;
    repeat (8) @(posedge clk);
    k <= 1'b0;
    k_n <= 1'b1;
    load_strobe_n <= (cmd != 3);
    dir <= 1'b0;
    dq_in <= (cmd == 1) ? d1 : ~dq_in;
    lane_write_mask_n <= m1;
    repeat (8) @(posedge clk);
  endtask : cycle
endmodule : dbsp_ctrl_model
`default_nettype wire

// >>> dv/ddr_burst_sram_port_bench.sv
// Purpose: self-checking bench of the burst sram port
// Assumes: one read word pair is expected per read command
// Notes: expectations come from a reference memory of word pairs
`timescale 1ns/1ps
`default_nettype none
module ddr_burst_sram_port_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic k, k_n, load_strobe_n, dir, dq_oe, read_valid_flag, write_buffer_ready, has_w1;
  logic [18:0] addr;
  logic [35:0] dq_in, dq_out, w1_hold;
  logic [3:0] lane_write_mask_n;
  logic [1:0] echo_strobes;
  logic [1:0] echo_prev = 2'h0;
  logic [1:0] link_prev = 2'h0;
  logic [71:0] cur;
  logic [71:0] exp_q[$];
  logic [71:0] pend_q[$];
  logic [71:0] ref_mem [int];
  logic [18:0] addrs [4] = '{19'h00000, 19'h7ffff, 19'h2a5a5, 19'h15a5a};
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  dbsp_port i_dut (.clk(clk), .rst(rst), .k(k), .k_n(k_n), .load_strobe_n(load_strobe_n), .dir(dir),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .lane_write_mask_n(lane_write_mask_n),
    .read_valid_flag(read_valid_flag), .echo_strobes(echo_strobes), .write_buffer_ready(write_buffer_ready));
  dbsp_ctrl_model i_ctrl (.clk(clk), .k(k), .k_n(k_n), .load_strobe_n(load_strobe_n), .dir(dir),
    .addr(addr), .dq_in(dq_in), .lane_write_mask_n(lane_write_mask_n));

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // lanes enabled by a low mask bit take the new data
  function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n, input logic [3:0] m);
    logic [35:0] e;
    e = {{9{~m[3]}}, {9{~m[2]}}, {9{~m[1]}}, {9{~m[0]}}};
    return (o & ~e) | (n & e);
  endfunction : mrg

  task automatic op(input int cmd, input logic [18:0] a, input logic [3:0] m0, input logic [3:0] m1);
    logic [35:0] d0, d1;
    logic [71:0] w;
    d0 = 36'({$urandom(), $urandom()});
    d1 = 36'({$urandom(), $urandom()});
    while (pend_q.size() > 0) exp_q.push_back(pend_q.pop_front());
    if (cmd == 1) begin
      w = ref_mem.exists(a) ? ref_mem[a] : '0;
      ref_mem[a] = {mrg(w[71:36], d1, m1), mrg(w[35:0], d0, m0)};
    end
    if (cmd == 2) pend_q.push_back(ref_mem[a]);
    i_ctrl.cycle(cmd, a, d0, m0, d1, m1);
  endtask : op

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************************
  // output monitor
  // ****************************************************
  always @(negedge clk) begin
    if (!rst) begin
      check(read_valid_flag === dq_oe, "valid flag differs from enable");
      if (cycles > 11) check(echo_strobes === link_prev, "echo strobes out of step");
      link_prev = {k_n, k};
      check(write_buffer_ready === 1'b1, "write buffer refused");
      if (echo_strobes[0] && !echo_prev[0]) begin
        if (exp_q.size() > 0) begin
          cur = exp_q.pop_front();
          check(dq_oe === 1'b1 && dq_out === cur[35:0], "first read word");
          w1_hold = cur[71:36];
          has_w1 = 1'b1;
        end else begin
          check(dq_oe === 1'b0, "driving with no read");
        end
      end
      if (echo_strobes[1] && !echo_prev[1] && has_w1 === 1'b1) begin
        check(dq_oe === 1'b1 && dq_out === w1_hold, "second read word");
        has_w1 = 1'b0;
      end
      echo_prev = echo_strobes;
    end
  end

  initial begin
    has_w1 = 1'b0;
    void'($urandom(15));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (addrs[i]) op(1, addrs[i], 4'h0, 4'h0);
    foreach (addrs[i]) op(2, addrs[i], 4'hf, 4'hf);
    op(0, 19'h0, 4'hf, 4'hf);
    $display("test full bursts done");
    for (int i = 0; i < 4; i++) begin
      op(1, addrs[i], ~(4'h1 << i), 4'($urandom()));
      op(2, addrs[i], 4'hf, 4'hf);
    end
    $display("test lane masks done");
    op(3, addrs[0], 4'h0, 4'h0);
    op(2, addrs[0], 4'hf, 4'hf);
    $display("test stray strobes done");
    repeat (3) op(0, 19'h0, 4'hf, 4'hf);
    check(exp_q.size() == 0 && pend_q.size() == 0 && has_w1 === 1'b0, "read data missing");
    end_sim();
  end
endmodule : ddr_burst_sram_port_bench
`default_nettype wire
